// ---- rtl/supervisor_params.svh ----
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

// register byte offsets
`define ADDR_LOW_CTL      12'h000
`define ADDR_HIGH_CTL     12'h004
`define ADDR_FLAGS        12'h008
`define ADDR_POWER        12'h00C
`define ADDR_STATE        12'h010

// low-side control fields
`define LO_SUP_EN_BIT     0
`define LO_SUP_KEEP_BIT   1
`define LO_SUP_FAST_BIT   2
`define LO_MON_EN_BIT     3
`define LO_MON_FAST_BIT   4
`define LO_AUTO_BIT       5
// high-side control fields
`define HI_SUP_EN_BIT     0
`define HI_SUP_KEEP_BIT   1
`define HI_SUP_FAST_BIT   2
`define HI_MON_EN_BIT     3
`define HI_MON_FAST_BIT   4
`define HI_AUTO_BIT       5
// power register fields
`define PW_LPM_BIT        0
`define PW_LEVEL_LSB      1
`define PW_LEVEL_MSB      2

`define LO_CTL_RESET      6'h05
`define HI_CTL_RESET      6'h05

// timing, in nanoseconds at a 100 ns clock
`define CLK_PERIOD_NS     100
`define SETTLE_FAST_NS    2000
`define SETTLE_SLOW_NS    150000
`define WAKE_FAST_NS      2000
`define WAKE_SLOW_NS      150000
`define SETTLE_FAST_CYC   (`SETTLE_FAST_NS / `CLK_PERIOD_NS)
`define SETTLE_SLOW_CYC   (`SETTLE_SLOW_NS / `CLK_PERIOD_NS)
`define WAKE_FAST_CYC     (`WAKE_FAST_NS / `CLK_PERIOD_NS)
`define WAKE_SLOW_CYC     (`WAKE_SLOW_NS / `CLK_PERIOD_NS)
`define HAZARD_NS         1000
`define HAZARD_CYC        (`HAZARD_NS / `CLK_PERIOD_NS)

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ---- rtl/supervisor_pkg.sv ----
package supervisor_pkg;

  // comparator operating state
  typedef enum logic [2:0] {
    UNIT_OFF    = 3'b001,
    UNIT_NORMAL = 3'b010,
    UNIT_FULL   = 3'b100
  } unit_state_e;

  // power sequencing state
  typedef enum logic [3:0] {
    PW_ACTIVE = 4'b0001,
    PW_SLEEP  = 4'b0010,
    PW_WAKE   = 4'b0100,
    PW_STUCK  = 4'b1000
  } power_state_e;

  typedef logic [15:0] count_t;

endpackage

// ---- rtl/low_side_supervisor_mode_control.sv ----
// Function
// - full-speed low supervisor gives about 2 us settling after configuration change.
// - core below requested level when settling ends causes device reset.
// - normal speed before raising core level gives about 150 us settling.
// - deep wake-up fast if low supervisor off or full speed, else slow.
// - active and modes 0/1: off when disabled, else normal or full speed.
// - deep modes: manual keeps state if keep bit; auto normal only if keep and fast.
// - high monitor deep modes: manual keeps state; auto off or normal if fast.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "supervisor_params.svh"

module low_side_supervisor_mode_control
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // power unit side
  input  wire logic        core_level_reached,
  input  wire logic        wake_event,
  input  wire logic        external_reset,
  input  wire logic        watchdog_timer_reset,
  output logic             device_reset_req,
  output logic             cpu_hold,
  output logic [2:0]       low_supervisor_state,
  output logic [2:0]       low_monitor_state,
  output logic [2:0]       high_monitor_state
);

  // state decode for the three comparators
  function automatic logic [2:0] unit_state(input logic en, input logic fast,
                                            input logic deep, input logic keep_sel,
                                            input logic auto_normal);
    logic [2:0] active_st;
    active_st = !en ? supervisor_pkg::UNIT_OFF
                    : (fast ? supervisor_pkg::UNIT_FULL : supervisor_pkg::UNIT_NORMAL);
    if (!deep)
      unit_state = active_st;
    else if (keep_sel)
      unit_state = active_st;
    else if (en && auto_normal)
      unit_state = supervisor_pkg::UNIT_NORMAL;
    else
      unit_state = supervisor_pkg::UNIT_OFF;
  endfunction

  // registers
  logic [5:0]                  low_ctl_q;
  logic [5:0]                  high_ctl_q;
  logic                        low_settle_pending_flag_q;
  logic                        high_settle_pending_flag_q;
  logic                        lpm_req_q;
  logic [1:0]                  core_level_q;
  supervisor_pkg::count_t      low_cnt_q;
  supervisor_pkg::count_t      high_cnt_q;
  supervisor_pkg::count_t      wake_cnt_q;
  supervisor_pkg::count_t      hazard_cnt_q;
  supervisor_pkg::power_state_e pw_q;
  logic                        aw_hold_q;
  logic                        w_hold_q;
  logic [11:0]                 awaddr_q;
  logic [31:0]                 wdata_q;
  logic [3:0]                  wstrb_q;
  logic                        unit_reset_q;

  // control field views
  wire lo_en      = low_ctl_q[`LO_SUP_EN_BIT];
  wire lo_keep    = low_ctl_q[`LO_SUP_KEEP_BIT];
  wire lo_fast    = low_ctl_q[`LO_SUP_FAST_BIT];
  wire lo_mon_en  = low_ctl_q[`LO_MON_EN_BIT];
  wire lo_mon_fst = low_ctl_q[`LO_MON_FAST_BIT];
  wire lo_auto    = low_ctl_q[`LO_AUTO_BIT];
  wire hi_mon_en  = high_ctl_q[`HI_MON_EN_BIT];
  wire hi_mon_fst = high_ctl_q[`HI_MON_FAST_BIT];
  wire hi_auto    = high_ctl_q[`HI_AUTO_BIT];
  wire deep       = (pw_q == supervisor_pkg::PW_SLEEP) || (pw_q == supervisor_pkg::PW_STUCK);

  // write channel: address and data taken independently, in either order
  wire        aw_have   = aw_hold_q || s_axi_awvalid;
  wire        w_have    = w_hold_q || s_axi_wvalid;
  wire        wr_fire   = aw_have && w_have && !s_axi_bvalid;
  wire [11:0] wr_addr   = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data   = w_hold_q ? wdata_q : s_axi_wdata;
  wire [3:0]  wr_strb   = w_hold_q ? wstrb_q : s_axi_wstrb;
  wire        wr_low    = wr_fire && wr_addr == `ADDR_LOW_CTL;
  wire        wr_high   = wr_fire && wr_addr == `ADDR_HIGH_CTL;
  wire        wr_power  = wr_fire && wr_addr == `ADDR_POWER;
  wire        wr_ro     = wr_fire && (wr_addr == `ADDR_FLAGS || wr_addr == `ADDR_STATE);
  wire        wr_ok     = wr_low || wr_high || wr_power || wr_ro;
  wire        wr_b0     = wr_strb[0];

  // normal speed gives the long settle
  wire supervisor_pkg::count_t low_settle_len =
    lo_fast ? 16'(`SETTLE_FAST_CYC) : 16'(`SETTLE_SLOW_CYC);
  wire supervisor_pkg::count_t high_settle_len =
    high_ctl_q[`HI_SUP_FAST_BIT] ? 16'(`SETTLE_FAST_CYC) : 16'(`SETTLE_SLOW_CYC);
  wire [5:0] low_next  = wr_data[5:0];
  wire       low_next_fast = low_next[`LO_SUP_FAST_BIT];
  wire [5:0] high_next = wr_data[5:0];
  wire       high_next_fast = high_next[`HI_SUP_FAST_BIT];

  // wake timing from the low supervisor setting
  wire slow_wake = lo_en && !lo_fast;
  wire supervisor_pkg::count_t wake_len =
    slow_wake ? 16'(`WAKE_SLOW_CYC) : 16'(`WAKE_FAST_CYC);

  // settle expiry with core short of its target
  wire low_expire   = low_settle_pending_flag_q && low_cnt_q == 16'h0001;
  wire core_fail    = low_expire && !core_level_reached;

  // power sequencing
  wire       sleep_req   = lpm_req_q;
  wire       hazard_hit  = (pw_q == supervisor_pkg::PW_SLEEP) && wake_event
                           && hazard_cnt_q != 16'h0000 && !slow_wake;
  // recovery sources for the stuck condition
  wire       recover     = external_reset || watchdog_timer_reset;

  // read mux
  wire [31:0] rd_low   = {26'h000_0000, low_ctl_q};
  wire [31:0] rd_high  = {26'h000_0000, high_ctl_q};
  wire [31:0] rd_flags = {30'h0000_0000, high_settle_pending_flag_q, low_settle_pending_flag_q};
  wire [31:0] rd_power = {29'h0000_0000, core_level_q, lpm_req_q};
  wire [31:0] rd_state = {19'h0_0000, pw_q, low_supervisor_state, low_monitor_state,
                          high_monitor_state};
  wire        rd_hit   = s_axi_araddr == `ADDR_LOW_CTL || s_axi_araddr == `ADDR_HIGH_CTL ||
                         s_axi_araddr == `ADDR_FLAGS || s_axi_araddr == `ADDR_POWER ||
                         s_axi_araddr == `ADDR_STATE;
  wire [31:0] rd_val   = s_axi_araddr == `ADDR_LOW_CTL  ? rd_low   :
                         s_axi_araddr == `ADDR_HIGH_CTL ? rd_high  :
                         s_axi_araddr == `ADDR_FLAGS    ? rd_flags :
                         s_axi_araddr == `ADDR_POWER    ? rd_power :
                         s_axi_araddr == `ADDR_STATE    ? rd_state : 32'h0000_0000;
  wire        rd_fire  = s_axi_arvalid && s_axi_arready;

  wire [2:0] lsup_d = unit_state(lo_en, lo_fast, deep, !lo_auto && lo_keep,
                                 lo_auto && lo_keep && lo_fast);
  // low monitor follows the high monitor mapping, without the keep bit
  wire [2:0] lmon_d = unit_state(lo_mon_en, lo_mon_fst, deep, !lo_auto,
                                 lo_auto && lo_mon_fst);
  wire [2:0] hmon_d = unit_state(hi_mon_en, hi_mon_fst, deep, !hi_auto,
                                 hi_auto && hi_mon_fst);

  // bus handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !wr_fire)
      begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_fire)
      begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_hold_q     <= 1'b0;
        w_hold_q      <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel, one cycle to answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control registers; only byte lane 0 carries fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_ctl_q    <= `LO_CTL_RESET;
      high_ctl_q   <= `HI_CTL_RESET;
      lpm_req_q    <= 1'b0;
      core_level_q <= 2'h0;
    end
    else
    begin
      if (wr_low && wr_b0)
        low_ctl_q <= low_next;
      if (wr_high && wr_b0)
        high_ctl_q <= high_next;
      if (wr_power && wr_b0)
      begin
        lpm_req_q    <= wr_data[`PW_LPM_BIT];
        core_level_q <= wr_data[`PW_LEVEL_MSB:`PW_LEVEL_LSB];
      end
      // wake completion or stuck recovery drops request
      // else the recovered core would fall straight back into sleep
      else if ((pw_q == supervisor_pkg::PW_WAKE && wake_cnt_q == 16'h0001)
               || (pw_q == supervisor_pkg::PW_STUCK && recover))
        lpm_req_q <= 1'b0;
    end
  end

  // settle flags: a new write restarts the delay, so set wins over expiry
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_settle_pending_flag_q  <= 1'b0;
      high_settle_pending_flag_q <= 1'b0;
      low_cnt_q                  <= 16'h0000;
      high_cnt_q                 <= 16'h0000;
    end
    else
    begin
      if (wr_low && wr_b0)
      begin
        low_settle_pending_flag_q <= 1'b1;
        low_cnt_q <= low_next_fast ? 16'(`SETTLE_FAST_CYC) : 16'(`SETTLE_SLOW_CYC);
      end
      else if (wr_power && wr_b0 && wr_data[`PW_LEVEL_MSB:`PW_LEVEL_LSB] != core_level_q)
      begin
        low_settle_pending_flag_q <= 1'b1;
        low_cnt_q                 <= low_settle_len;
      end
      else if (low_settle_pending_flag_q)
      begin
        low_cnt_q <= low_cnt_q - 16'h0001;
        if (low_cnt_q == 16'h0001)
          low_settle_pending_flag_q <= 1'b0;
      end
      if (wr_high && wr_b0)
      begin
        high_settle_pending_flag_q <= 1'b1;
        high_cnt_q <= high_next_fast ? 16'(`SETTLE_FAST_CYC) : 16'(`SETTLE_SLOW_CYC);
      end
      else if (high_settle_pending_flag_q)
      begin
        high_cnt_q <= high_cnt_q - 16'h0001;
        if (high_cnt_q == 16'h0001)
          high_settle_pending_flag_q <= 1'b0;
      end
    end
  end

  // power sequencing; the stuck state models the wake hazard and only reset clears it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pw_q         <= supervisor_pkg::PW_ACTIVE;
      wake_cnt_q   <= 16'h0000;
      hazard_cnt_q <= 16'h0000;
      cpu_hold     <= 1'b0;
      unit_reset_q <= 1'b0;
    end
    else
    begin
      unit_reset_q <= core_fail;
      unique case (pw_q)
        supervisor_pkg::PW_ACTIVE:
          if (sleep_req)
          begin
            pw_q         <= supervisor_pkg::PW_SLEEP;
            hazard_cnt_q <= 16'(`HAZARD_CYC);
            cpu_hold     <= 1'b1;
          end
        supervisor_pkg::PW_SLEEP:
        begin
          if (hazard_cnt_q != 16'h0000)
            hazard_cnt_q <= hazard_cnt_q - 16'h0001;
          if (hazard_hit)
            pw_q <= supervisor_pkg::PW_STUCK;
          else if (wake_event)
          begin
            pw_q       <= supervisor_pkg::PW_WAKE;
            wake_cnt_q <= wake_len;
          end
        end
        supervisor_pkg::PW_WAKE:
        begin
          wake_cnt_q <= wake_cnt_q - 16'h0001;
          if (wake_cnt_q == 16'h0001)
          begin
            pw_q     <= supervisor_pkg::PW_ACTIVE;
            cpu_hold <= 1'b0;
          end
        end
        supervisor_pkg::PW_STUCK:
          // leave stuck only on a recovery source
          if (recover)
          begin
            pw_q     <= supervisor_pkg::PW_ACTIVE;
            cpu_hold <= 1'b0;
          end
      endcase
    end
  end

  // registered comparator states and reset request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_supervisor_state <= supervisor_pkg::UNIT_OFF;
      low_monitor_state    <= supervisor_pkg::UNIT_OFF;
      high_monitor_state   <= supervisor_pkg::UNIT_OFF;
      device_reset_req     <= 1'b0;
    end
    else
    begin
      low_supervisor_state <= lsup_d;
      low_monitor_state    <= lmon_d;
      high_monitor_state   <= hmon_d;
      // device reset on failed core rise or on a recovery source leaving stuck
      device_reset_req     <= unit_reset_q || (pw_q == supervisor_pkg::PW_STUCK && recover);
    end
  end

endmodule

// ---- dv/supervisor_checker.sv ----
`timescale 1ns/1ps
`include "supervisor_params.svh"

module supervisor_checker
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // power side
  input wire logic        device_reset_req,
  input wire logic        cpu_hold,
  input wire logic [2:0]  low_supervisor_state,
  input wire logic [2:0]  low_monitor_state
);
  logic [5:0] lo_q;
  logic [1:0] up_q;
  wire        wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire        lo_wr   = wr_take && s_axi_awaddr == `ADDR_LOW_CTL && s_axi_wstrb[0];
  wire [2:0]  sup_act = !lo_q[0] ? 3'h1 : (lo_q[2] ? 3'h4 : 3'h2);
  wire [2:0]  mon_act = !lo_q[3] ? 3'h1 : (lo_q[4] ? 3'h4 : 3'h2);

  // shadow of the low control word, so decode can be judged without the body
  always_ff @(posedge aclk)
    if (!aresetn) lo_q <= `LO_CTL_RESET;
    else if (lo_wr) lo_q <= s_axi_wdata[5:0];
  // decode check waits three edges after reset release
  always_ff @(posedge aclk)
    if (!aresetn) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;

  sequence s_sleep_req;
    wr_take && s_axi_awaddr == `ADDR_POWER && s_axi_wstrb[0] && s_axi_wdata[0] && !cpu_hold;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_WR_ANSWER: assert property (wr_take |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing one cycle after take");
  AST_RD_ANSWER: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data missing one cycle after take");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  AST_UNMAPPED: assert property (wr_take && s_axi_awaddr > `ADDR_STATE |-> ##[1:4]
    (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR))
    else $error("unmapped write not refused");
  AST_RESET_PULSE: assert property ($rose(device_reset_req) |=> !device_reset_req)
    else $error("device reset request longer than one cycle");
  AST_SLEEP_ENTRY: assert property (s_sleep_req |-> ##[1:2] cpu_hold)
    else $error("cpu hold not raised on deep entry");
  AST_ONE_HOT: assert property ($onehot(low_supervisor_state)
    && $onehot(low_monitor_state))
    else $error("comparator state not one-hot");
  AST_ACTIVE_DECODE: assert property (up_q == 2'h3 && !cpu_hold && !$past(cpu_hold)
    && lo_q == $past(lo_q) |-> low_supervisor_state == sup_act && low_monitor_state == mon_act)
    else $error("active-mode comparator state wrong");
endmodule

bind low_side_supervisor_mode_control supervisor_checker i_supervisor_checker
(
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .device_reset_req, .cpu_hold,
  .low_supervisor_state, .low_monitor_state
);

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`include "supervisor_params.svh"

module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        core_level_reached = 1'b1, wake_event = 1'b0;
  logic        external_reset = 1'b0, watchdog_timer_reset = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        device_reset_req, cpu_hold;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0]  low_supervisor_state, low_monitor_state, high_monitor_state;
  int          fail_count = 0, n_tests = 0, cyc = 0, pulses = 0;

  low_side_supervisor_mode_control i_low_side_supervisor_mode_control
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .core_level_reached, .wake_event, .external_reset, .watchdog_timer_reset, .device_reset_req,
    .cpu_hold, .low_supervisor_state, .low_monitor_state, .high_monitor_state
  );

  always #50 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  always @(posedge aclk) if (device_reset_req === 1'b1) pulses <= pulses + 1;

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // both readies idle high, so address and data are taken on one edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    // bready sometimes late, so the response must hold
    if ($urandom % 2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    if ($urandom % 2) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic settle(input logic [1:0] first, output int dt);
    logic [31:0] d;
    logic [1:0]  r;
    int          t0;
    t0 = cyc;
    rd(`ADDR_FLAGS, d, r);
    chk(d[1:0] & first, first);
    while (d[1:0] !== 2'h0 && cyc - t0 < 3000) rd(`ADDR_FLAGS, d, r);
    dt = cyc - t0;
  endtask

  task automatic cfg(input logic [5:0] lo, input logic [5:0] hi, output int dt);
    logic [1:0] r;
    wr(`ADDR_HIGH_CTL, {26'h0, hi}, r);
    wr(`ADDR_LOW_CTL, {26'h0, lo}, r);
    settle(2'h3, dt);
  endtask

  function automatic logic [31:0] ok_time(input int dt, input bit slow);
    return 32'(slow ? (dt > 1400 && dt < 1560) : (dt < 60));
  endfunction

  function automatic logic [2:0] sup_e(input logic [5:0] c, input bit deep);
    if (!c[0] || (deep && (c[5] ? !(c[1] && c[2]) : !c[1]))) return supervisor_pkg::UNIT_OFF;
    if (deep && c[5]) return supervisor_pkg::UNIT_NORMAL;
    return c[2] ? supervisor_pkg::UNIT_FULL : supervisor_pkg::UNIT_NORMAL;
  endfunction

  // monitor fields sit in the same places in both control words
  function automatic logic [2:0] mon_e(input logic [5:0] c, input bit deep);
    if (!c[3] || (deep && c[5] && !c[4])) return supervisor_pkg::UNIT_OFF;
    if (deep && c[5]) return supervisor_pkg::UNIT_NORMAL;
    return c[4] ? supervisor_pkg::UNIT_FULL : supervisor_pkg::UNIT_NORMAL;
  endfunction

  initial
  begin
    repeat (90000) @(posedge aclk);
    fail_count++;
    give_verdict;
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [5:0]  lo, hi;
    int          dt, p, k;
    void'($urandom(32'h7b87439e));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ADDR_LOW_CTL, d, r);
    chk(d, `LO_CTL_RESET);
    rd(`ADDR_HIGH_CTL, d, r);
    chk(d, `HI_CTL_RESET);
    rd(`ADDR_STATE, d, r);
    chk(d, {19'h0, 4'h1, sup_e(`LO_CTL_RESET, 0), mon_e(`LO_CTL_RESET, 0),
            mon_e(`HI_CTL_RESET, 0)});
    $display("test reset_values done");
    for (int i = 0; i < 8; i++)
    begin
      lo = (i == 0) ? 6'h00 : 6'($urandom);
      hi = 6'($urandom);
      cfg(lo, hi, dt);
      chk(ok_time(dt, !(lo[2] && hi[2])), 32'h1);
      chk(low_supervisor_state, sup_e(lo, 0));
      chk(low_monitor_state, mon_e(lo, 0));
      chk(high_monitor_state, mon_e(hi, 0));
    end
    $display("test active_decode done");
    // late core level under fast settling must reset, under slow it must not
    cfg(6'h07, 6'h07, dt);
    core_level_reached <= 1'b0;
    p = pulses;
    wr(`ADDR_POWER, 32'h4, r);
    settle(2'h1, dt);
    repeat (5) @(posedge aclk);
    chk(pulses - p, 32'h1);
    core_level_reached <= 1'b1;
    cfg(6'h03, 6'h07, dt);
    core_level_reached <= 1'b0;
    p = pulses;
    wr(`ADDR_POWER, 32'h6, r);
    fork
      settle(2'h1, dt);
      begin
        repeat (500) @(posedge aclk);
        core_level_reached <= 1'b1;
      end
    join
    chk(ok_time(dt, 1), 32'h1);
    chk(pulses - p, 32'h0);
    $display("test core_level done");
    for (int i = 0; i < 6; i++)
    begin
      lo = (i == 0) ? 6'h27 : (i == 1) ? 6'h03 : 6'($urandom);
      hi = 6'($urandom);
      cfg(lo, hi, dt);
      wr(`ADDR_POWER, 32'h7, r);
      repeat (15) @(posedge aclk);
      chk(cpu_hold, 32'h1);
      chk(low_supervisor_state, sup_e(lo, 1));
      chk(low_monitor_state, mon_e(lo, 1));
      chk(high_monitor_state, mon_e(hi, 1));
      wake_event <= 1'b1;
      @(posedge aclk);
      wake_event <= 1'b0;
      for (k = 0; cpu_hold === 1'b1 && k < 3000; k++) @(posedge aclk);
      chk(ok_time(k, lo[0] && !lo[2]), 32'h1);
      repeat (100) @(posedge aclk);
      rd(`ADDR_POWER, d, r);
      chk(d, 32'h6);
    end
    $display("test deep_wake done");
    for (int s = 0; s < 2; s++)
    begin
      cfg(6'h07, 6'h07, dt);
      wr(`ADDR_POWER, 32'h7, r);
      @(posedge aclk);
      wake_event <= 1'b1;
      @(posedge aclk);
      wake_event <= 1'b0;
      repeat (100) @(posedge aclk);
      rd(`ADDR_STATE, d, r);
      chk(d[12:9], supervisor_pkg::PW_STUCK);
      p = pulses;
      external_reset <= (s == 0);
      watchdog_timer_reset <= (s == 1);
      @(posedge aclk);
      external_reset <= 1'b0;
      watchdog_timer_reset <= 1'b0;
      repeat (10) @(posedge aclk);
      chk(cpu_hold, 32'h0);
      chk(pulses - p, 32'h1);
    end
    $display("test stuck_recovery done");
    wr(12'h020, 32'h0000_00ff, r);
    chk(r, `RESP_SLVERR);
    rd(12'h020, d, r);
    chk(r, `RESP_SLVERR);
    chk(d, 32'h0);
    wr(`ADDR_FLAGS, 32'h3, r);
    chk(r, `RESP_OKAY);
    $display("test bus_errors done");
    give_verdict;
  end
endmodule
